//--- core/gpes_event_ctrl.sv
// Event redirect control with APB slave, pin 7 drive and interrupt.
// Assumes port event and notification inputs are on clk_sys.
//
// The APB slave port was decided locally.
`timescale 1ns/10ps
`default_nettype none

module gpes_event_ctrl
	import gpes_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Ports 2, 3, 4: event level and in-band notification
	input wire logic [2:0] portEvent,
	input wire logic [2:0] notifyReq,
	output logic [2:0] notifyFwd,
	// General-purpose pin 7
	input wire logic gpio7AltSel,
	output logic gpio7Out,
	output logic gpio7Oe,
	// Event level and interrupt
	output logic gpEventOut,
	output logic irq
);

	// ==========================================================
	// State
	typedef struct packed {
		logic invert;
		logic [2:0] redirEn;
		logic [2:0] pending;
		logic [2:0] intSts;
		logic [2:0] intMask;
		logic irq;
		logic eventOut;
		logic pinOut;
		logic pinOe;
		logic [2:0] notifyFwd;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} gpes_state_t;

	localparam gpes_state_t GPES_STATE_RESET = '{
		invert: GPES_CTRL_RESET[GPES_CTRL_INVERT],
		redirEn: GPES_CTRL_RESET[GPES_CTRL_EN_LSB +: GPES_PORTS],
		pending: GPES_STS_RESET[GPES_STS_LSB +: GPES_PORTS],
		intSts: 3'h0,
		intMask: GPES_MASK_RESET,
		irq: 1'b0,
		eventOut: 1'b1,
		pinOut: 1'b1,
		pinOe: 1'b0,
		notifyFwd: 3'h0,
		prdata: 32'h0000_0000,
		pready: 1'b0,
		pslverr: 1'b0
	};

	gpes_state_t s;
	gpes_state_t next_s;
	logic [1:0] rstSync;
	logic rstN;
	logic wrEn;
	logic anyPending;

	// ==========================================================
	// Functions
	function automatic logic mapped(input logic [11:0] a);
		mapped = (a == GPES_ADDR_CTRL) || (a == GPES_ADDR_STS) ||
			(a == GPES_ADDR_INT_STS) || (a == GPES_ADDR_INT_MASK);
	endfunction

	// Active pin level for a given event state
	function automatic logic pinLevel(input logic inv,
		input logic active);
		pinLevel = inv ? active : ~active;
	endfunction

	function automatic logic [31:0] readWord(input gpes_state_t st,
		input logic [11:0] a);
		readWord = 32'h0000_0000;
		unique case (a)
			GPES_ADDR_CTRL: begin
				readWord[GPES_CTRL_INVERT] = st.invert;
				readWord[GPES_CTRL_EN_LSB +: GPES_PORTS] = st.redirEn;
			end
			GPES_ADDR_STS: begin
				readWord[GPES_STS_LSB +: GPES_PORTS] = st.pending;
			end
			GPES_ADDR_INT_STS: begin
				readWord[GPES_INT_LSB +: GPES_PORTS] = st.intSts;
			end
			GPES_ADDR_INT_MASK: begin
				readWord[GPES_INT_LSB +: GPES_PORTS] = st.intMask;
			end
			default: begin
				readWord = 32'h0000_0000;
			end
		endcase
	endfunction

	// ==========================================================
	// Reset release
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rstSync <= 2'h0;
		end else begin
			rstSync <= {rstSync[0], 1'b1};
		end
	end
	assign rstN = rstSync[1];

	assign wrEn = psel && penable && s.pready && pwrite;

	// ==========================================================
	// Next state
	always_comb begin
		next_s = s;

		// Zero-wait slave: data latched in setup, ready in access
		next_s.pready = psel && !penable;
		next_s.pslverr = psel && !penable && !mapped(paddr);
		if (psel && !penable && !pwrite) begin
			next_s.prdata = readWord(s, paddr);
		end

		if (wrEn && paddr == GPES_ADDR_CTRL) begin
			next_s.invert = pwdata[GPES_CTRL_INVERT];
			next_s.redirEn = pwdata[GPES_CTRL_EN_LSB +: GPES_PORTS];
		end
		if (wrEn && paddr == GPES_ADDR_INT_MASK) begin
			next_s.intMask = pwdata[GPES_INT_LSB +: GPES_PORTS];
		end

		// Pending only for redirected ports
		next_s.pending = s.redirEn & portEvent;

		// Redirected ports lose their in-band notifications
		next_s.notifyFwd = notifyReq & ~s.redirEn;

		// One shared output for all ports
		next_s.eventOut = pinLevel(next_s.invert,
			|next_s.pending);

		// Pin idles inactive when not in alternate function
		next_s.pinOe = gpio7AltSel;
		next_s.pinOut = gpio7AltSel ? next_s.eventOut :
			pinLevel(next_s.invert, 1'b0);

		// New pending edge sets sticky bit; set beats clear
		next_s.intSts = s.intSts;
		if (wrEn && paddr == GPES_ADDR_INT_STS) begin
			next_s.intSts = s.intSts &
				~pwdata[GPES_INT_LSB +: GPES_PORTS];
		end
		next_s.intSts = next_s.intSts | (next_s.pending & ~s.pending);
		next_s.irq = |(next_s.intSts & next_s.intMask);
	end

	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			s <= GPES_STATE_RESET;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// Outputs
	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign notifyFwd = s.notifyFwd;
	assign gpio7Out = s.pinOut;
	assign gpio7Oe = s.pinOe;
	assign gpEventOut = s.eventOut;
	assign irq = s.irq;

	assign anyPending = |s.pending;

	// ==========================================================
	// Checks
	pol_level_a: assert property (
		@(posedge clk_sys) disable iff (!rstN)
		s.eventOut == (s.invert ? anyPending : !anyPending))
		else $error("event level does not follow polarity");

	p2_suppress_a: assert property (
		@(posedge clk_sys) disable iff (!rstN)
		s.redirEn[0] |=> !s.notifyFwd[0])
		else $error("port 2 notification not suppressed");

	p3_suppress_a: assert property (
		@(posedge clk_sys) disable iff (!rstN)
		s.redirEn[1] && notifyReq[1] |=> !s.notifyFwd[1])
		else $error("port 3 notification not suppressed");

	p4_forward_a: assert property (
		@(posedge clk_sys) disable iff (!rstN)
		notifyReq[2] |=> s.notifyFwd[2] != $past(s.redirEn[2]))
		else $error("port 4 notification routing wrong");

	sts_read_a: assert property (
		@(posedge clk_sys) disable iff (!rstN)
		psel && !penable && !pwrite && paddr == GPES_ADDR_STS
		|=> prdata == {28'h000_0000, $past(s.pending), 1'b0})
		else $error("status read mismatch");

	no_enable_a: assert property (
		@(posedge clk_sys) disable iff (!rstN)
		(s.pending & ~$past(s.redirEn)) == 3'h0)
		else $error("status set without enable");

	pin_alt_a: assert property (
		@(posedge clk_sys) disable iff (!rstN)
		gpio7Oe == $past(gpio7AltSel) &&
		(gpio7Oe -> gpio7Out == gpEventOut))
		else $error("pin 7 not gated by alternate select");

	or_assert_a: assert property (
		@(posedge clk_sys) disable iff (!rstN)
		$rose(anyPending) |-> gpEventOut == s.invert)
		else $error("event not asserted for pending port");

	irq_level_a: assert property (
		@(posedge clk_sys) disable iff (!rstN)
		irq == |(s.intSts & s.intMask))
		else $error("irq disagrees with status and mask");

	// ==========================================================
	// Checks: register access

	ready_after_setup_a: assert property (
		@(posedge clk_sys) disable iff (!rstN)
		psel && !penable |=> pready)
		else $error("pready missing after setup");

	ready_single_a: assert property (
		@(posedge clk_sys) disable iff (!rstN)
		pready |-> $past(psel && !penable))
		else $error("pready without a setup cycle");

	err_with_ready_a: assert property (
		@(posedge clk_sys) disable iff (!rstN)
		pslverr |-> pready)
		else $error("pslverr outside access cycle");

	unmapped_err_a: assert property (
		@(posedge clk_sys) disable iff (!rstN)
		psel && !penable && !mapped(paddr) |=> pslverr)
		else $error("unmapped address not flagged");

	unmapped_read_a: assert property (
		@(posedge clk_sys) disable iff (!rstN)
		psel && !penable && !pwrite && !mapped(paddr)
		|=> prdata == 32'h0000_0000)
		else $error("unmapped read not zero");

	ctrl_read_a: assert property (
		@(posedge clk_sys) disable iff (!rstN)
		psel && !penable && !pwrite && paddr == GPES_ADDR_CTRL
		|=> prdata == {27'h000_0000, $past(s.redirEn), 1'b0,
			$past(s.invert)})
		else $error("control read mismatch");

	ctrl_write_a: assert property (
		@(posedge clk_sys) disable iff (!rstN)
		wrEn && paddr == GPES_ADDR_CTRL
		|=> s.invert == $past(pwdata[GPES_CTRL_INVERT]) &&
		s.redirEn == $past(pwdata[GPES_CTRL_EN_LSB +: GPES_PORTS]))
		else $error("control write not applied");

	ctrl_hold_a: assert property (
		@(posedge clk_sys) disable iff (!rstN)
		!(wrEn && paddr == GPES_ADDR_CTRL)
		|=> $stable(s.invert) && $stable(s.redirEn))
		else $error("control changed without a write");

	mask_write_a: assert property (
		@(posedge clk_sys) disable iff (!rstN)
		wrEn && paddr == GPES_ADDR_INT_MASK
		|=> s.intMask == $past(pwdata[GPES_INT_LSB +: GPES_PORTS]))
		else $error("mask write not applied");

	// ==========================================================
	// Checks: event routing

	pend_follow_a: assert property (
		@(posedge clk_sys) disable iff (!rstN)
		s.pending == ($past(s.redirEn) & $past(portEvent)))
		else $error("status does not follow enabled events");

	event_held_a: assert property (
		@(posedge clk_sys) disable iff (!rstN)
		anyPending |-> gpEventOut == s.invert)
		else $error("event output not active while pending");

	event_idle_a: assert property (
		@(posedge clk_sys) disable iff (!rstN)
		!anyPending |-> gpEventOut == !s.invert)
		else $error("event output active with nothing pending");

	pin_idle_a: assert property (
		@(posedge clk_sys) disable iff (!rstN)
		!gpio7Oe |-> gpio7Out == !s.invert)
		else $error("released pin 7 not at inactive level");

	notify_pass_a: assert property (
		@(posedge clk_sys) disable iff (!rstN)
		notifyFwd == ($past(notifyReq) & ~$past(s.redirEn)))
		else $error("notification routing wrong");

	// ==========================================================
	// Checks: interrupt

	int_set_a: assert property (
		@(posedge clk_sys) disable iff (!rstN)
		(s.pending & ~$past(s.pending) & ~s.intSts) == 3'h0)
		else $error("new event did not set sticky bit");

	int_clear_a: assert property (
		@(posedge clk_sys) disable iff (!rstN)
		wrEn && paddr == GPES_ADDR_INT_STS
		|=> (s.intSts & $past(pwdata[GPES_INT_LSB +: GPES_PORTS]) &
		~(s.pending & ~$past(s.pending))) == 3'h0)
		else $error("sticky bit not cleared by write");

	int_sticky_a: assert property (
		@(posedge clk_sys) disable iff (!rstN)
		!(wrEn && paddr == GPES_ADDR_INT_STS)
		|=> ($past(s.intSts) & ~s.intSts) == 3'h0)
		else $error("sticky bit dropped without a write");

	irq_masked_a: assert property (
		@(posedge clk_sys) disable iff (!rstN)
		s.intMask == 3'h0 |-> !irq)
		else $error("irq raised with all sources masked");

endmodule // gpes_event_ctrl

`default_nettype wire

//--- pkg/gpes_pkg.sv
// Constants for the general purpose event redirect block.
// Assumes a 32-bit APB master and a 12-bit register address.
`default_nettype none

package gpes_pkg;

	// ==========================================================
	// Register map
	localparam logic [11:0] GPES_ADDR_CTRL = 12'h35C;
	localparam logic [11:0] GPES_ADDR_STS = 12'h360;
	localparam logic [11:0] GPES_ADDR_INT_STS = 12'h364;
	localparam logic [11:0] GPES_ADDR_INT_MASK = 12'h368;

	// ==========================================================
	// Field positions
	localparam int GPES_CTRL_INVERT = 0;
	localparam int GPES_CTRL_EN_LSB = 2;
	localparam int GPES_STS_LSB = 1;
	localparam int GPES_INT_LSB = 0;
	localparam int GPES_PORTS = 3;

	// ==========================================================
	// Reset values
	localparam logic [31:0] GPES_CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] GPES_STS_RESET = 32'h0000_0000;
	localparam logic [2:0] GPES_MASK_RESET = 3'h0;

	// ==========================================================
	// Timing: status, pin and interrupt follow inputs in cycles
	localparam int GPES_EVENT_LATENCY = 1;

endpackage

`default_nettype wire

//--- tb/general_purpose_event_signalling_test.sv
// Bench for the event redirect block: APB register and pin tests.
// Assumes a pull-up on pin 7 and the watcher as the system side.
`timescale 1ns/10ps
`default_nettype none

module general_purpose_event_signalling_test
	import gpes_pkg::*;
;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, gpio7Out, gpio7Oe, gpEventOut, irq, seen;
	logic [2:0] portEvent = 3'h0;
	logic [2:0] notifyReq = 3'h0;
	logic [2:0] notifyFwd;
	logic gpio7AltSel = 1'b0;
	logic invert = 1'b0;
	logic [31:0] q;
	logic e;
	int nFail = 0;
	int nTests = 0;

	always #4 clk_sys = ~clk_sys;

	gpes_event_ctrl dut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.portEvent(portEvent), .notifyReq(notifyReq), .notifyFwd(notifyFwd),
		.gpio7AltSel(gpio7AltSel), .gpio7Out(gpio7Out), .gpio7Oe(gpio7Oe),
		.gpEventOut(gpEventOut), .irq(irq));
	// Released pin floats up through the board pull-up
	gpes_event_watcher watcher (.clk_sys(clk_sys),
		.pinWire(gpio7Oe ? gpio7Out : 1'b1), .activeHigh(invert),
		.eventSeen(seen));

	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		nTests++;
		if (got !== exp) begin
			nFail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(q, exp);
	endtask

	task automatic settle();
		repeat (3) @(posedge clk_sys);
	endtask

	task automatic endSim();
		$display("checks %0d, mismatches %0d", nTests, nFail);
		if (nFail == 0 && nTests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		repeat (2000) @(posedge clk_sys);
		nFail++;
		endSim();
	end

	// ==========================================================
	// Tests
	initial begin
		repeat (3) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rd(GPES_ADDR_CTRL, GPES_CTRL_RESET);
		chk({31'h0, e}, 32'h0);
		rd(GPES_ADDR_STS, GPES_STS_RESET);
		rd(GPES_ADDR_INT_MASK, 32'h0);
		rd(12'h000, 32'h0);
		chk({31'h0, e}, 32'h1);
		apb(1'b1, GPES_ADDR_STS, 32'hFFFF_FFFF);
		rd(GPES_ADDR_STS, 32'h0);
		apb(1'b1, GPES_ADDR_CTRL, 32'hFFFF_FFFF);
		rd(GPES_ADDR_CTRL, 32'h0000_001D);
		apb(1'b1, GPES_ADDR_CTRL, 32'h0);
		$display("test registers done");
		portEvent <= 3'h7;
		notifyReq <= 3'h7;
		settle();
		rd(GPES_ADDR_STS, 32'h0);
		chk({29'h0, notifyFwd}, 32'h7);
		chk({31'h0, gpEventOut}, 32'h1);
		$display("test disabled done");
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, GPES_ADDR_CTRL, 32'h4 << i);
			settle();
			rd(GPES_ADDR_STS, 32'h1 << (i + 1));
			chk({29'h0, notifyFwd}, 32'h7 & ~(32'h1 << i));
			chk({31'h0, gpEventOut}, 32'h0);
		end
		$display("test per port done");
		apb(1'b1, GPES_ADDR_CTRL, 32'h0000_001C);
		portEvent <= 3'h4;
		settle();
		chk({31'h0, gpEventOut}, 32'h0);
		gpio7AltSel <= 1'b1;
		settle();
		chk({30'h0, gpio7Oe, seen}, 32'h3);
		gpio7AltSel <= 1'b0;
		settle();
		chk({30'h0, gpio7Oe, seen}, 32'h0);
		portEvent <= 3'h0;
		settle();
		chk({31'h0, gpEventOut}, 32'h1);
		$display("test pin done");
		rd(GPES_ADDR_INT_STS, 32'h7);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, GPES_ADDR_INT_MASK, 32'h1);
		settle();
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, GPES_ADDR_INT_STS, 32'h7);
		rd(GPES_ADDR_INT_STS, 32'h0);
		chk({31'h0, irq}, 32'h0);
		$display("test interrupt done");
		apb(1'b1, GPES_ADDR_CTRL, 32'h0000_001D);
		invert <= 1'b1;
		gpio7AltSel <= 1'b1;
		settle();
		chk({30'h0, gpEventOut, seen}, 32'h0);
		portEvent <= 3'h2;
		settle();
		chk({30'h0, gpEventOut, seen}, 32'h3);
		$display("test polarity done");
		endSim();
	end
endmodule // general_purpose_event_signalling_test

`default_nettype wire

//--- tb/gpes_event_watcher.sv
// System-side watcher of the shared event pin.
// Assumes the bench resolves the pin wire, pull-up when released.
`timescale 1ns/10ps
`default_nettype none

module gpes_event_watcher (
	// Clock
	input wire logic clk_sys,
	// Pin and polarity
	input wire logic pinWire,
	input wire logic activeHigh,
	// Seen event
	output logic eventSeen
);
	// ==========================================================
	// Registered sample, as a real input synchroniser would
	always_ff @(posedge clk_sys) begin
		eventSeen <= activeHigh ? pinWire : ~pinWire;
	end
endmodule // gpes_event_watcher

`default_nettype wire
